// ---- logic/conv_out_ctrl.sv ----
// digital output control of a 10-bit pipelined sampling converter
// assumes the encode strobe pair and select pins are asynchronous pins,
// sampled by CORE_CLK; quantiser results arrive as a raw code plus over and under flags
//
// Summary of operation
// - a conversion starts when the positive strobe rises above the negative.
// - each captured sample leaves as an output word five encode cycles later.
// - power-down low and enable low: convert and drive the outputs.
// - power-down low and enable high: convert but float the outputs.
// - power-down high and enable low: nap mode, outputs floated.
// - power-down high and enable high: sleep mode, outputs floated.
// - the word is ten bits wide with bit 9 the most significant.
// - the flag is high for any sample beyond either end of the range.
// - the four-level select picks number format and stabilizer together.
// - while the strobe is low the input is tracked.
// - on the rising edge the tracked value freezes into stage one.
// - stages alternate phases, odd ones outputting while even ones acquire.
// - stage results are time-aligned and merged before the output driver.
// - the sample-to-word latency is a fixed count of encode cycles.
module conv_out_ctrl (
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  input  wire logic       SAMPLE_STROBE_P,
  input  wire logic       SAMPLE_STROBE_N,
  input  wire logic [9:0] ANALOG_CODE,
  input  wire logic       ANALOG_OVER,
  input  wire logic       ANALOG_UNDER,
  input  wire logic       POWER_DOWN_SELECT,
  input  wire logic       OUTPUT_ENABLE_N,
  input  wire logic [1:0] FORMAT_SELECT,
  output logic [9:0]      SAMPLE_WORD,
  output logic [9:0]      SAMPLE_WORD_OE,
  output logic            RANGE_OVERFLOW_FLAG,
  output logic            RANGE_OVERFLOW_OE,
  output logic            DATA_VALID_STROBE,
  output logic            DATA_VALID_OE,
  output logic            STABILIZER_ON,
  output logic            FIFO_OVERRUN
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       sp_s, sn_s, pd_s, oen_s;
  logic [1:0] fmt_s;
  logic [9:0] code_s;
  logic       ovr_s, und_s;

  conv_sync u_sp (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (SAMPLE_STROBE_P),
    .dout  (sp_s)
  );

  conv_sync u_sn (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (SAMPLE_STROBE_N),
    .dout  (sn_s)
  );

  conv_sync u_pd (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (POWER_DOWN_SELECT),
    .dout  (pd_s)
  );

  conv_sync u_oe (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (OUTPUT_ENABLE_N),
    .dout  (oen_s)
  );

  conv_sync u_ov (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (ANALOG_OVER),
    .dout  (ovr_s)
  );

  conv_sync u_un (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (ANALOG_UNDER),
    .dout  (und_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_fmt
      conv_sync u_f (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .din   (FORMAT_SELECT[gi]),
        .dout  (fmt_s[gi])
      );
    end
    for (gi = 0; gi < 10; gi++)
    begin : g_code
      conv_sync u_c (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .din   (ANALOG_CODE[gi]),
        .dout  (code_s[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // encode phase and edges
  // ---------------------------------------------------------------
  logic enc_q, enc_d;
  logic rise, fall;
  logic enc_hi;
  conv_pkg::power_mode_t mode;
  logic converting;

  always_comb
  begin
    enc_hi = sp_s & ~sn_s;
    enc_d  = enc_hi;
    rise   = enc_hi & ~enc_q;
    fall   = ~enc_hi & enc_q;
    case ({pd_s, oen_s})
      2'b00:   mode = conv_pkg::MODE_RUN;
      2'b01:   mode = conv_pkg::MODE_RUN_HIZ;
      2'b10:   mode = conv_pkg::MODE_NAP;
      default: mode = conv_pkg::MODE_SLEEP;
    endcase
    converting = (mode == conv_pkg::MODE_RUN) ||
                 (mode == conv_pkg::MODE_RUN_HIZ);
  end

  // ---------------------------------------------------------------
  // track/hold and stage pipeline
  // ---------------------------------------------------------------
  // even slots load on the encode rise and odd slots on the fall, so
  // neighbouring stages always work in opposite phases; the align slots
  // then pad the path out to the full latency in whole encode cycles
  localparam int ALIGN = conv_pkg::LATENCY - (conv_pkg::STAGES + 1) / 2;

  conv_pkg::sample_t           track_q, track_d;
  conv_pkg::sample_t           pipe_q [conv_pkg::STAGES];
  conv_pkg::sample_t           pipe_d [conv_pkg::STAGES];
  conv_pkg::sample_t           align_q [ALIGN];
  conv_pkg::sample_t           align_d [ALIGN];
  logic [conv_pkg::STAGES-1:0] vld_q, vld_d;
  logic [ALIGN-1:0]            avld_q, avld_d;

  always_comb
  begin
    track_d = track_q;
    if (!enc_hi)
    begin
      track_d.word = code_s;
      track_d.ovf  = ovr_s | und_s;
    end
    pipe_d  = pipe_q;
    vld_d   = vld_q;
    align_d = align_q;
    avld_d  = avld_q;
    if (!converting)
    begin
      vld_d  = '0;
      avld_d = '0;
    end
    else
    begin
      if (rise)
      begin
        pipe_d[0] = track_q;
        vld_d[0]  = 1'b1;
      end
      for (int k = 1; k < conv_pkg::STAGES; k++)
      begin
        if ((k % 2 == 1) ? fall : rise)
        begin
          pipe_d[k] = pipe_q[k-1];
          vld_d[k]  = vld_q[k-1];
        end
      end
      // the align slots only move on the rise, so the word leaves a
      // whole number of encode cycles after its capture
      if (rise)
      begin
        align_d[0] = pipe_q[conv_pkg::STAGES-1];
        avld_d[0]  = vld_q[conv_pkg::STAGES-1];
        for (int k = 1; k < ALIGN; k++)
        begin
          align_d[k] = align_q[k-1];
          avld_d[k]  = avld_q[k-1];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      enc_q   <= 1'b0;
      track_q <= '0;
      vld_q   <= '0;
      avld_q  <= '0;
      for (int k = 0; k < conv_pkg::STAGES; k++)
        pipe_q[k] <= '0;
      for (int k = 0; k < ALIGN; k++)
        align_q[k] <= '0;
    end
    else
    begin
      enc_q   <= enc_d;
      track_q <= track_d;
      vld_q   <= vld_d;
      avld_q  <= avld_d;
      pipe_q  <= pipe_d;
      align_q <= align_d;
    end
  end

  // ---------------------------------------------------------------
  // format conversion and output fifo
  // ---------------------------------------------------------------
  logic [1:0]        fmt_q, fmt_d;
  conv_pkg::sample_t fmt_word;
  logic              f_in_ready, f_out_valid, f_out_ready;
  logic [10:0]       f_out_data;
  logic              push;

  always_comb
  begin
    fmt_d    = fmt_s;
    fmt_word = align_q[ALIGN-1];
    if (fmt_q == conv_pkg::FMT_TC_STAB_ON ||
        fmt_q == conv_pkg::FMT_TC_STAB_OFF)
      fmt_word.word[9] = ~fmt_word.word[9];
    push = rise && converting && avld_q[ALIGN-1];
  end

  conv_fifo #(.WIDTH(11), .DEPTH(conv_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .in_data   (fmt_word),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // ---------------------------------------------------------------
  // output register and strobe
  // ---------------------------------------------------------------
  // one word leaves per encode fall; strobe rises with the word and
  // falls on the next rise, giving the receiver a clean falling edge
  logic [9:0] word_d;
  logic       ovf_d, dv_d, oe_d, stab_d, ovrun_d;

  always_comb
  begin
    f_out_ready = fall;
    word_d      = SAMPLE_WORD;
    ovf_d       = RANGE_OVERFLOW_FLAG;
    dv_d        = DATA_VALID_STROBE;
    if (fall && f_out_valid)
    begin
      word_d = f_out_data[9:0];
      ovf_d  = f_out_data[10];
      dv_d   = 1'b1;
    end
    else if (rise)
      dv_d = 1'b0;
    oe_d    = (mode == conv_pkg::MODE_RUN);
    stab_d  = (fmt_q == conv_pkg::FMT_OB_STAB_ON) ||
              (fmt_q == conv_pkg::FMT_TC_STAB_ON);
    // limitation: overrun only occurs if falls are missed; sticky
    ovrun_d = FIFO_OVERRUN | (push & ~f_in_ready);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      fmt_q               <= conv_pkg::FMT_RST;
      SAMPLE_WORD         <= conv_pkg::WORD_RST;
      RANGE_OVERFLOW_FLAG <= 1'b0;
      DATA_VALID_STROBE   <= 1'b0;
      SAMPLE_WORD_OE      <= '0;
      RANGE_OVERFLOW_OE   <= 1'b0;
      DATA_VALID_OE       <= 1'b0;
      STABILIZER_ON       <= 1'b0;
      FIFO_OVERRUN        <= 1'b0;
    end
    else
    begin
      fmt_q               <= fmt_d;
      SAMPLE_WORD         <= word_d;
      RANGE_OVERFLOW_FLAG <= ovf_d;
      DATA_VALID_STROBE   <= dv_d;
      SAMPLE_WORD_OE      <= {10{oe_d}};
      RANGE_OVERFLOW_OE   <= oe_d;
      DATA_VALID_OE       <= oe_d;
      STABILIZER_ON       <= stab_d;
      FIFO_OVERRUN        <= ovrun_d;
    end
  end

endmodule

// ---- logic/conv_pkg.sv ----
// package for the pipelined converter output control
// assumes a single core clock domain; the encode strobe is sampled as data
package conv_pkg;

  localparam int WORD_W          = 10;
  localparam int LATENCY         = 5;
  localparam int FIFO_DEPTH      = 8;
  localparam int STAGES          = 5;
  localparam int STAGE_BITS      = 2;

  // reset values
  localparam logic [9:0] WORD_RST = 10'h000;
  localparam logic [1:0] FMT_RST  = 2'h0;

  // four-level format select, coded as sampled by the pin decoder
  localparam logic [1:0] FMT_OB_STAB_OFF = 2'h0;
  localparam logic [1:0] FMT_OB_STAB_ON  = 2'h1;
  localparam logic [1:0] FMT_TC_STAB_ON  = 2'h2;
  localparam logic [1:0] FMT_TC_STAB_OFF = 2'h3;

  localparam logic [9:0] OB_MAX = 10'h3ff;
  localparam logic [9:0] OB_MIN = 10'h000;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_RUN_HIZ,
    MODE_NAP,
    MODE_SLEEP
  } power_mode_t;

  typedef struct packed {
    logic       ovf;
    logic [9:0] word;
  } sample_t;

endpackage

// ---- logic/conv_sync.sv ----
// two-flop synchroniser for one asynchronous level
// assumes clk is the core clock; the first flop feeds only the second
module conv_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic dout_d;

  always_comb
  begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end

endmodule

// ---- logic/conv_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock; read data comes combinationally from the array
module conv_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb
  begin
    in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    out_valid = (cnt_q != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_d      = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d      = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d     = cnt_q;
    if (push && !pop)
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    else if (pop && !push)
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    out_data  = mem_q[rp_q];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wp_q] <= in_data;
  end

endmodule

// ---- sim/conv_out_ctrl_props.sv ----
// concurrent checks on the converter output control pins
// assumes it is bound into conv_out_ctrl by the bind at the foot
module conv_out_ctrl_props (
  input wire logic       CORE_CLK,
  input wire logic       RESET_N,
  input wire logic       SAMPLE_STROBE_P,
  input wire logic       SAMPLE_STROBE_N,
  input wire logic       POWER_DOWN_SELECT,
  input wire logic       OUTPUT_ENABLE_N,
  input wire logic [1:0] FORMAT_SELECT,
  input wire logic [9:0] SAMPLE_WORD,
  input wire logic [9:0] SAMPLE_WORD_OE,
  input wire logic       RANGE_OVERFLOW_FLAG,
  input wire logic       RANGE_OVERFLOW_OE,
  input wire logic       DATA_VALID_STROBE,
  input wire logic       DATA_VALID_OE,
  input wire logic       STABILIZER_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  wire enc = SAMPLE_STROBE_P & ~SAMPLE_STROBE_N;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // ----
  // six cycles cover the two-flop sync plus the output register
  // ----
  oe_run_a: assert property (
    (!POWER_DOWN_SELECT && !OUTPUT_ENABLE_N)[*6] |-> &SAMPLE_WORD_OE)
    else $error("run mode not driving");
  hiz_oen_a: assert property (
    OUTPUT_ENABLE_N[*6] |-> SAMPLE_WORD_OE == 10'h000 && !DATA_VALID_OE)
    else $error("disabled yet driving");
  hiz_pd_a: assert property (
    POWER_DOWN_SELECT[*6] |-> !RANGE_OVERFLOW_OE && !DATA_VALID_OE)
    else $error("nap or sleep yet driving");
  oe_tie_a: assert property (
    {SAMPLE_WORD_OE, RANGE_OVERFLOW_OE} == {11{DATA_VALID_OE}})
    else $error("drive enables disagree");
  // format is applied before the fifo, so the whole word must hold
  hold_flag_a: assert property (
    DATA_VALID_STROBE && $past(DATA_VALID_STROBE)
    |-> $stable({RANGE_OVERFLOW_FLAG, SAMPLE_WORD}))
    else $error("word moved under strobe");
  stab_level_a: assert property (
    $stable(FORMAT_SELECT)[*6] |-> STABILIZER_ON == ^FORMAT_SELECT)
    else $error("stabilizer wrong");
  strobe_drop_a: assert property (
    !POWER_DOWN_SELECT && $rose(enc) |-> ##[1:5] !DATA_VALID_STROBE)
    else $error("strobe kept after rise");
  strobe_low_a: assert property (
    enc[*6] |-> !DATA_VALID_STROBE)
    else $error("strobe high in high phase");
endmodule

bind conv_out_ctrl conv_out_ctrl_props u_conv_out_ctrl_props (.*);

// ---- sim/capture_model.sv ----
// downstream capture logic latching word and flag on the strobe's fall
// assumes the bench resolves the three-state pins onto these lines
module capture_model (
  input wire logic       strobe_line,
  input wire logic [9:0] word_line,
  input wire logic       flag_line
);
  timeunit 1ns;
  timeprecision 1ps;
  conv_pkg::sample_t got [$];
  logic              prev_strobe = 1'b0;
  // only a driven high-to-low step latches; a line floating into or
  // out of high impedance is no fall
  always @(strobe_line)
  begin
    if (prev_strobe === 1'b1 && strobe_line === 1'b0)
      got.push_back({flag_line, word_line});
    prev_strobe = strobe_line;
  end
endmodule

// ---- sim/test_conv_out_ctrl.sv ----
// self-checking bench for the converter output control
// assumes package, design, checker and capture model compile first
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("unexpected at %0t: %h vs %h", $time, a, b); \
    end \
  end
module test_conv_out_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, sp = 1'b0, sn = 1'b1;
  logic       ovr = 1'b0, und = 1'b0, pd = 1'b0, oen = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [9:0] code = 10'h000, word, word_oe;
  logic       flag, flag_oe, dvs, dvs_oe, stab, overrun;
  wire  [9:0] word_line;
  wire        flag_line, dvs_line;
  int         n_fail = 0, samples_checked = 0;

  always #10 clk = ~clk;
  assign word_line = word_oe == 10'h3ff ? word : 10'hzzz;
  assign flag_line = flag_oe ? flag : 1'bz;
  assign dvs_line = dvs_oe ? dvs : 1'bz;

  conv_out_ctrl u_conv_out_ctrl (
    .CORE_CLK(clk), .RESET_N(rst_n), .SAMPLE_STROBE_P(sp),
    .SAMPLE_STROBE_N(sn), .ANALOG_CODE(code), .ANALOG_OVER(ovr),
    .ANALOG_UNDER(und), .POWER_DOWN_SELECT(pd), .OUTPUT_ENABLE_N(oen),
    .FORMAT_SELECT(fmt), .SAMPLE_WORD(word), .SAMPLE_WORD_OE(word_oe),
    .RANGE_OVERFLOW_FLAG(flag), .RANGE_OVERFLOW_OE(flag_oe),
    .DATA_VALID_STROBE(dvs), .DATA_VALID_OE(dvs_oe),
    .STABILIZER_ON(stab), .FIFO_OVERRUN(overrun)
  );
  capture_model u_capture_model (
    .strobe_line(dvs_line), .word_line(word_line), .flag_line(flag_line)
  );
  // ----
  // scenarios: encode edges on falling clock edges, 160 ns period
  // ----
  task automatic enc_cycle(input logic [11:0] s, input int hi);
    @(negedge clk);
    {und, ovr, code} = s;
    repeat (3) @(negedge clk);
    {sp, sn} = 2'h2;
    repeat (hi / 20) @(negedge clk);
    {sp, sn} = 2'h1;
  endtask

  // a nap with the encode running empties the pipeline and drops a
  // strobe left standing, so each scenario starts clean
  task automatic restart(input logic [1:0] f, input logic p, input logic e);
    @(negedge clk);
    {fmt, pd} = {f, 1'b1};
    repeat (2) enc_cycle(12'h000, 80);
    {pd, oen} = {p, e};
    repeat (8) @(negedge clk);
    u_capture_model.got.delete();
  endtask

  task automatic t_stream(input logic [1:0] f);
    logic [11:0] s [4];
    conv_pkg::sample_t e;
    s = '{12'h3ff, 12'h000, 12'h5a5, 12'h801};
    restart(f, 1'b0, 1'b0);
    foreach (s[i]) enc_cycle(s[i], 80);
    for (int k = 0; k < 6; k++) enc_cycle(12'h0c3, k == 5 ? 200 : 80);
    `CHK(u_capture_model.got.size(), 4)
    foreach (s[i])
    begin
      e = {|s[i][11:10], s[i][9:0] ^ {f[1], 9'h000}};
      `CHK(u_capture_model.got[i], e)
    end
    `CHK(stab, ^f)
    $display("stream done, format %0d", f);
  endtask

  task automatic t_hiz;
    restart(2'h0, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) enc_cycle(12'h100 + 12'(k), 80);
    `CHK({word_oe, flag_oe}, 11'h000)
    @(negedge clk);
    oen = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(word_oe, 10'h3ff)
    repeat (2) enc_cycle(12'h000, 80);
    `CHK(u_capture_model.got.size(), 2)
    `CHK({u_capture_model.got[0], u_capture_model.got[1]}, 22'h080101)
    $display("disable done");
  endtask

  task automatic t_sleep;
    for (int e = 0; e < 2; e++)
    begin
      restart(2'h0, 1'b1, e[0]);
      repeat (8) enc_cycle(12'h2aa, 80);
      `CHK({word_oe, dvs_oe}, 11'h000)
      `CHK(u_capture_model.got.size(), 0)
    end
    $display("nap and sleep done");
  endtask

  task automatic tally_and_finish;
    $display("checked %0d, mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int f = 0; f < 4; f++) t_stream(f[1:0]);
    t_hiz();
    t_sleep();
    `CHK(overrun, 1'b0)
    tally_and_finish();
  end
endmodule
